// File: cfm_defs.svh
// register indices, field positions and reset values of the clock fault monitor
`ifndef CFM_DEFS_SVH
`define CFM_DEFS_SVH

`define CFM_IDX_SOFT_MASK 10'h1d6
`define CFM_IDX_EXT_MASK 10'h1d7
`define CFM_IDX_STATUS 10'h1d8
`define CFM_IDX_REF_WINDOW 10'h1d9
`define CFM_IDX_EXPECT 10'h1da
`define CFM_IDX_PPM_STATUS 10'h1dd

`define CFM_MASK_RST 16'hffff
`define CFM_STATUS_RST 12'h000
`define CFM_REF_WINDOW_RST 14'h30d3
`define CFM_EXPECT_RST 16'hf423

`define CFM_NUM_SRC 12
`define CFM_REF_WINDOW_W 14
`define CFM_REG_W 16

`define CFM_BIT_PLL_LOCKDET 11
`define CFM_BIT_SYS_FREQ 10
`define CFM_BIT_SYS_PPM 9
`define CFM_BIT_SYS_DEAD 8
`define CFM_BIT_LD_DEAD 7
`define CFM_BIT_PLL_FREQ 6
`define CFM_BIT_PLL_PPM 5
`define CFM_BIT_PLL_DEAD 4
`define CFM_BIT_RECOV_DEAD 3
`define CFM_BIT_ADC_DEAD 2
`define CFM_BIT_PM_FAULT 1
`define CFM_BIT_RST_FAULT 0

`define CFM_RESP_OKAY 2'b00
`define CFM_RESP_SLVERR 2'b10

`endif

// File: cfm_pkg.sv
// types shared by the clock fault monitor modules
package cfm_pkg;

    typedef enum logic [1:0] {
        CFM_WR_IDLE = 2'b00,
        CFM_WR_HAVE_ADDR = 2'b01,
        CFM_WR_HAVE_DATA = 2'b10,
        CFM_WR_RESP = 2'b11
    } cfm_wr_state_t;

    typedef struct packed {
        logic [11:0] det_meta;
        logic [11:0] det_sync;
        logic [1:0] tog_meta;
        logic [1:0] tog_sync;
        logic [1:0] tog_last;
        logic [15:0] soft_mask;
        logic [15:0] ext_mask;
        logic [11:0] status;
        logic [13:0] ref_window;
        logic [15:0] expect_count;
        cfm_wr_state_t wr_state;
        logic [9:0] wr_idx;
        logic [31:0] wr_data;
        logic [3:0] wr_strb;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic soft_req;
        logic irq_n;
    } cfm_state_t;

endpackage

// File: cfm_ppm_window.sv
// ppm measurement window: reference counter and monitored-cycle capture
`include "cfm_defs.svh"

module cfm_ppm_window
    import cfm_pkg::*;
#(
    parameter int CNT_W = `CFM_REG_W,
    parameter int WIN_W = `CFM_REF_WINDOW_W,
    parameter logic [CNT_W-1:0] CAP_RST = `CFM_EXPECT_RST
)
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic ref_edge,
    input wire logic mon_edge,
    input wire logic [WIN_W-1:0] window_count,
    output logic [CNT_W-1:0] captured,
    output logic window_done
);

    if (WIN_W < 1 || CNT_W < 2 || WIN_W > CNT_W)
    begin : g_bad_width
        $error("cfm_ppm_window: unsupported counter widths");
    end

    typedef struct packed {
        logic [WIN_W-1:0] ref_cnt;
        logic [CNT_W-1:0] mon_cnt;
        logic [CNT_W-1:0] cap;
        logic done;
    } cfm_ppm_state_t;

    cfm_ppm_state_t s;
    cfm_ppm_state_t next_s;
    logic [CNT_W-1:0] mon_inc;

    always_comb
    begin
        next_s = s;
        next_s.done = 1'b0;
        // monitored counter wraps freely, as a fast clock may overrun
        mon_inc = s.mon_cnt + {{(CNT_W-1){1'b0}}, mon_edge};
        next_s.mon_cnt = mon_inc;
        if (ref_edge)
        begin
            if (s.ref_cnt >= window_count)
            begin
                // window of window_count+1 reference cycles ends
                next_s.ref_cnt = '0;
                next_s.cap = mon_inc;
                next_s.mon_cnt = '0;
                next_s.done = 1'b1;
            end
            else
            begin
                next_s.ref_cnt = s.ref_cnt + {{(WIN_W-1){1'b0}}, 1'b1};
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            s.ref_cnt <= '0;
            s.mon_cnt <= '0;
            s.cap <= CAP_RST;
            s.done <= 1'b0;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign captured = s.cap;
    assign window_done = s.done;

endmodule // cfm_ppm_window

// File: cfm_monitor.sv
// clock fault monitor: sticky status, recovery masks, ppm window, axi4-lite
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`include "cfm_defs.svh"

module cfm_monitor
    import cfm_pkg::*;
#(
    parameter int ADDR_W = 12,
    parameter int ADC_CHANNELS = 4
)
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic pll_lockdetect_failure,
    input wire logic system_clock_frequency_unlock,
    input wire logic system_clock_ppm_unlock,
    input wire logic system_clock_dead,
    input wire logic line_driver_clock_dead,
    input wire logic pll_output_frequency_unlock,
    input wire logic pll_output_ppm_unlock,
    input wire logic pll_output_clock_dead,
    input wire logic recovered_clock_dead,
    input wire logic [ADC_CHANNELS-1:0] converter_clock_dead,
    input wire logic power_manager_fault,
    input wire logic reset_unit_fault,
    input wire logic reference_toggle,
    input wire logic monitored_toggle,
    output logic soft_reset_request,
    output logic recovery_interrupt_pin_n,
    output logic ppm_window_done
);

    if (ADDR_W < 12 || ADDR_W > 32 || ADC_CHANNELS < 1)
    begin : g_bad_param
        $error("cfm_monitor: unsupported parameter values");
    end

    cfm_state_t s;
    cfm_state_t next_s;
    logic [11:0] det_raw;
    logic [11:0] clear_bits;
    logic ref_edge;
    logic mon_edge;
    logic aw_take;
    logic w_take;
    logic ar_take;
    logic do_write;
    logic [9:0] wr_idx;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic [15:0] ppm_captured;
    logic [15:0] clear_word;
    logic [15:0] win_word;

    // byte-lane merge of a 16-bit register
    function automatic logic [15:0] cfm_merge(
        input logic [15:0] old,
        input logic [31:0] data,
        input logic [3:0] strb
    );
        logic [15:0] res;
        res = old;
        if (strb[0])
        begin
            res[7:0] = data[7:0];
        end
        if (strb[1])
        begin
            res[15:8] = data[15:8];
        end
        return res;
    endfunction

    // true for every mapped register index
    function automatic logic cfm_mapped(input logic [9:0] idx);
        return idx == `CFM_IDX_SOFT_MASK || idx == `CFM_IDX_EXT_MASK
            || idx == `CFM_IDX_STATUS || idx == `CFM_IDX_REF_WINDOW
            || idx == `CFM_IDX_EXPECT || idx == `CFM_IDX_PPM_STATUS;
    endfunction

    // word index from a byte address
    function automatic logic [9:0] cfm_index(
        input logic [ADDR_W-1:0] addr
    );
        return addr[11:2];
    endfunction

    // raw detector levels in status bit order
    always_comb
    begin
        det_raw = '0;
        det_raw[`CFM_BIT_PLL_LOCKDET] = pll_lockdetect_failure;
        det_raw[`CFM_BIT_SYS_FREQ] = system_clock_frequency_unlock;
        det_raw[`CFM_BIT_SYS_PPM] = system_clock_ppm_unlock;
        det_raw[`CFM_BIT_SYS_DEAD] = system_clock_dead;
        det_raw[`CFM_BIT_LD_DEAD] = line_driver_clock_dead;
        det_raw[`CFM_BIT_PLL_FREQ] = pll_output_frequency_unlock;
        det_raw[`CFM_BIT_PLL_PPM] = pll_output_ppm_unlock;
        det_raw[`CFM_BIT_PLL_DEAD] = pll_output_clock_dead;
        det_raw[`CFM_BIT_RECOV_DEAD] = recovered_clock_dead;
        det_raw[`CFM_BIT_ADC_DEAD] = |converter_clock_dead;
        det_raw[`CFM_BIT_PM_FAULT] = power_manager_fault;
        det_raw[`CFM_BIT_RST_FAULT] = reset_unit_fault;
    end

    // toggles from the divided clocks become one-cycle edge pulses
    assign ref_edge = s.tog_sync[0] ^ s.tog_last[0];
    assign mon_edge = s.tog_sync[1] ^ s.tog_last[1];

    cfm_ppm_window #(
        .CNT_W(`CFM_REG_W),
        .WIN_W(`CFM_REF_WINDOW_W),
        .CAP_RST(`CFM_EXPECT_RST)
    ) u_ppm (
        .mclk(mclk),
        .nrst(nrst),
        .ref_edge(ref_edge),
        .mon_edge(mon_edge),
        .window_count(s.ref_window),
        .captured(ppm_captured),
        .window_done(ppm_window_done)
    );

    // write channel handshakes
    assign s_axi_awready = (s.wr_state == CFM_WR_IDLE)
        || (s.wr_state == CFM_WR_HAVE_DATA);
    assign s_axi_wready = (s.wr_state == CFM_WR_IDLE)
        || (s.wr_state == CFM_WR_HAVE_ADDR);
    assign s_axi_bvalid = (s.wr_state == CFM_WR_RESP);
    assign s_axi_bresp = s.bresp;
    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take = s_axi_wvalid && s_axi_wready;

    // read channel handshakes
    assign s_axi_arready = !s.rvalid;
    assign s_axi_rvalid = s.rvalid;
    assign s_axi_rdata = s.rdata;
    assign s_axi_rresp = s.rresp;
    assign ar_take = s_axi_arvalid && s_axi_arready;

    // address and data of the write, from the bus or from the hold
    assign wr_idx = aw_take ? cfm_index(s_axi_awaddr) : s.wr_idx;
    assign wr_data = w_take ? s_axi_wdata : s.wr_data;
    assign wr_strb = w_take ? s_axi_wstrb : s.wr_strb;

    always_comb
    begin
        case (s.wr_state)
            CFM_WR_IDLE: do_write = aw_take && w_take;
            CFM_WR_HAVE_ADDR: do_write = w_take;
            CFM_WR_HAVE_DATA: do_write = aw_take;
            default: do_write = 1'b0;
        endcase
    end

    // lane-merged write words for the status and window registers
    assign clear_word = cfm_merge(16'h0000, wr_data, wr_strb);
    assign win_word = cfm_merge({2'b00, s.ref_window}, wr_data, wr_strb);

    // write-one-to-clear bits of the status register
    always_comb
    begin
        clear_bits = '0;
        if (do_write && wr_idx == `CFM_IDX_STATUS)
        begin
            clear_bits = clear_word[11:0];
        end
    end

    always_comb
    begin
        next_s = s;
        next_s.det_meta = det_raw;
        next_s.det_sync = s.det_meta;
        next_s.tog_meta = {monitored_toggle, reference_toggle};
        next_s.tog_sync = s.tog_meta;
        next_s.tog_last = s.tog_sync;
        // a new event wins over a clear in the same cycle
        next_s.status = (s.status & ~clear_bits) | s.det_sync;

        // write channel sequence
        case (s.wr_state)
            CFM_WR_IDLE:
            begin
                if (aw_take && w_take)
                begin
                    next_s.wr_state = CFM_WR_RESP;
                end
                else if (aw_take)
                begin
                    next_s.wr_state = CFM_WR_HAVE_ADDR;
                end
                else if (w_take)
                begin
                    next_s.wr_state = CFM_WR_HAVE_DATA;
                end
            end
            CFM_WR_HAVE_ADDR:
            begin
                if (w_take)
                begin
                    next_s.wr_state = CFM_WR_RESP;
                end
            end
            CFM_WR_HAVE_DATA:
            begin
                if (aw_take)
                begin
                    next_s.wr_state = CFM_WR_RESP;
                end
            end
            CFM_WR_RESP:
            begin
                if (s_axi_bready)
                begin
                    next_s.wr_state = CFM_WR_IDLE;
                end
            end
            default:
            begin
                next_s.wr_state = CFM_WR_IDLE;
            end
        endcase
        next_s.wr_idx = wr_idx;
        next_s.wr_data = wr_data;
        next_s.wr_strb = wr_strb;

        if (do_write)
        begin
            next_s.bresp = cfm_mapped(wr_idx) ? `CFM_RESP_OKAY
                : `CFM_RESP_SLVERR;
            case (wr_idx)
                `CFM_IDX_SOFT_MASK:
                begin
                    next_s.soft_mask = cfm_merge(s.soft_mask, wr_data,
                        wr_strb);
                end
                `CFM_IDX_EXT_MASK:
                begin
                    next_s.ext_mask = cfm_merge(s.ext_mask, wr_data,
                        wr_strb);
                end
                `CFM_IDX_REF_WINDOW:
                begin
                    next_s.ref_window = win_word[13:0];
                end
                `CFM_IDX_EXPECT:
                begin
                    next_s.expect_count = cfm_merge(s.expect_count, wr_data,
                        wr_strb);
                end
                default:
                begin
                    next_s.expect_count = s.expect_count;
                end
            endcase
        end

        // read channel: data taken from the registers at the address edge
        if (ar_take)
        begin
            next_s.rvalid = 1'b1;
            next_s.rresp = `CFM_RESP_OKAY;
            case (cfm_index(s_axi_araddr))
                `CFM_IDX_SOFT_MASK: next_s.rdata = {16'h0000, s.soft_mask};
                `CFM_IDX_EXT_MASK: next_s.rdata = {16'h0000, s.ext_mask};
                `CFM_IDX_STATUS: next_s.rdata = {20'h00000, s.status};
                `CFM_IDX_REF_WINDOW: next_s.rdata = {18'h0, s.ref_window};
                `CFM_IDX_EXPECT: next_s.rdata = {16'h0000, s.expect_count};
                `CFM_IDX_PPM_STATUS: next_s.rdata = {16'h0000, ppm_captured};
                default:
                begin
                    next_s.rdata = 32'h00000000;
                    next_s.rresp = `CFM_RESP_SLVERR;
                end
            endcase
        end
        else if (s.rvalid && s_axi_rready)
        begin
            next_s.rvalid = 1'b0;
        end

        // recovery actions follow the masked sticky status
        next_s.soft_req = |(s.status & s.soft_mask[11:0]);
        next_s.irq_n = ~|(s.status & s.ext_mask[11:0]);
    end

    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            s.det_meta <= '0;
            s.det_sync <= '0;
            // toggle chain keeps tracking so release brings no false edge
            s.tog_meta <= next_s.tog_meta;
            s.tog_sync <= next_s.tog_sync;
            s.tog_last <= next_s.tog_last;
            s.soft_mask <= `CFM_MASK_RST;
            s.ext_mask <= `CFM_MASK_RST;
            s.status <= `CFM_STATUS_RST;
            s.ref_window <= `CFM_REF_WINDOW_RST;
            s.expect_count <= `CFM_EXPECT_RST;
            s.wr_state <= CFM_WR_IDLE;
            s.wr_idx <= '0;
            s.wr_data <= '0;
            s.wr_strb <= '0;
            s.bresp <= `CFM_RESP_OKAY;
            s.rvalid <= 1'b0;
            s.rdata <= '0;
            s.rresp <= `CFM_RESP_OKAY;
            s.soft_req <= 1'b0;
            s.irq_n <= 1'b1;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign soft_reset_request = s.soft_req;
    assign recovery_interrupt_pin_n = s.irq_n;

endmodule // cfm_monitor

// File: cfm_monitor_asserts.sv
// concurrent checks on the clock fault monitor ports
`include "cfm_defs.svh"

module cfm_monitor_asserts
#(
    parameter int ADDR_W = 12
)
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic reference_toggle,
    input wire logic soft_reset_request,
    input wire logic recovery_interrupt_pin_n,
    input wire logic ppm_window_done
);
    logic [9:0] wr_idx, rd_idx;
    logic [3:0] wr_age, ref_age;
    logic ref_last;

    function automatic logic mapped(input logic [9:0] i);
        return i inside {[`CFM_IDX_SOFT_MASK:`CFM_IDX_EXPECT],
            `CFM_IDX_PPM_STATUS};
    endfunction

    // cycles since a write answer and since a reference toggle
    always_ff @(posedge mclk)
    begin
        ref_last <= reference_toggle;
        if (s_axi_awvalid && s_axi_awready)
            wr_idx <= s_axi_awaddr[11:2];
        if (s_axi_arvalid && s_axi_arready)
            rd_idx <= s_axi_araddr[11:2];
        if (!nrst || s_axi_bvalid)
            wr_age <= 4'h0;
        else if (wr_age != 4'hf)
            wr_age <= wr_age + 4'h1;
        if (!nrst || ref_last != reference_toggle)
            ref_age <= 4'h0;
        else if (ref_age != 4'hf)
            ref_age <= ref_age + 4'h1;
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);

    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response changed before taken");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read answer changed before taken");
    a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while answer pending");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready
        && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
        else $error("write answer late");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid)
        else $error("read answer late");
    a_wr_resp: assert property (s_axi_bvalid |-> s_axi_bresp ==
        (mapped(wr_idx) ? `CFM_RESP_OKAY : `CFM_RESP_SLVERR))
        else $error("wrong write response code");
    a_rd_unmapped: assert property (s_axi_rvalid && !mapped(rd_idx)
        |-> s_axi_rresp == `CFM_RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read answered wrongly");
    a_status_upper: assert property (
        s_axi_rvalid && rd_idx == `CFM_IDX_STATUS |-> s_axi_rdata[31:12] == 20'h0)
        else $error("status upper bits not zero");
    a_window_width: assert property (
        s_axi_rvalid && rd_idx == `CFM_IDX_REF_WINDOW |-> s_axi_rdata[31:14] == 18'h0)
        else $error("window count wider than 14 bits");
    a_pin_sticky: assert property (
        $rose(recovery_interrupt_pin_n) |-> wr_age <= 4'h3)
        else $error("recovery pin released without a write");
    a_soft_sticky: assert property (
        $fell(soft_reset_request) |-> wr_age <= 4'h3)
        else $error("soft reset request dropped without a write");
    a_done_pulse: assert property (
        ppm_window_done |=> !ppm_window_done)
        else $error("window done longer than one cycle");
    a_done_cause: assert property (
        ppm_window_done |-> ref_age <= 4'h8)
        else $error("window done without reference edge");

    c_window: cover property (ppm_window_done);
    c_pin: cover property ($fell(recovery_interrupt_pin_n));
    c_slverr: cover property (s_axi_bvalid && s_axi_bresp == `CFM_RESP_SLVERR);
endmodule // cfm_monitor_asserts

bind cfm_monitor cfm_monitor_asserts #(.ADDR_W(ADDR_W)) i_cfm_monitor_asserts (
    .mclk(mclk), .nrst(nrst), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .reference_toggle(reference_toggle),
    .soft_reset_request(soft_reset_request),
    .recovery_interrupt_pin_n(recovery_interrupt_pin_n),
    .ppm_window_done(ppm_window_done)
);

// File: tb_cfm_monitor.sv
// self-checking bench for the clock fault monitor
`include "cfm_defs.svh"

`define CHK(got, exp) \
    begin \
        cmp_count++; \
        if ((got) !== (exp)) \
        begin \
            mismatches++; \
            $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); \
        end \
    end

module tb_cfm_monitor;
    timeunit 1ns;
    timeprecision 1ps;

    logic mclk, nrst;
    logic [11:0] s_axi_awaddr, s_axi_araddr, det;
    logic [2:0] s_axi_awprot, s_axi_arprot;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb, conv;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic reference_toggle = 1'b0;
    logic monitored_toggle = 1'b0;
    logic soft_reset_request, recovery_interrupt_pin_n, ppm_window_done;
    int mismatches = 0;
    int cmp_count = 0;
    int tick = 0;
    int last_done = 0;
    int gap = 0;
    bit run = 0;
    int unsigned seed = 79399;
    int soft_m, ext_m, stat, refw, expc, ppm_cap;
    logic [9:0] idx [8] = '{10'h1d6, 10'h1d7, 10'h1d8, 10'h1d9, 10'h1da,
        10'h1dd, 10'h1d5, 10'h1db};

    cfm_monitor i_cfm_monitor (
        .mclk, .nrst, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .pll_lockdetect_failure(det[11]),
        .system_clock_frequency_unlock(det[10]),
        .system_clock_ppm_unlock(det[9]), .system_clock_dead(det[8]),
        .line_driver_clock_dead(det[7]),
        .pll_output_frequency_unlock(det[6]),
        .pll_output_ppm_unlock(det[5]), .pll_output_clock_dead(det[4]),
        .recovered_clock_dead(det[3]), .converter_clock_dead(conv),
        .power_manager_fault(det[1]), .reset_unit_fault(det[0]),
        .reference_toggle, .monitored_toggle, .soft_reset_request,
        .recovery_interrupt_pin_n, .ppm_window_done
    );

    function automatic int unsigned rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [33:0] exp_rd(input logic [9:0] i);
        case (i)
            `CFM_IDX_SOFT_MASK: return {2'b00, 16'h0, soft_m[15:0]};
            `CFM_IDX_EXT_MASK: return {2'b00, 16'h0, ext_m[15:0]};
            `CFM_IDX_STATUS: return {2'b00, 20'h0, stat[11:0]};
            `CFM_IDX_REF_WINDOW: return {2'b00, 18'h0, refw[13:0]};
            `CFM_IDX_EXPECT: return {2'b00, 16'h0, expc[15:0]};
            `CFM_IDX_PPM_STATUS: return {2'b00, 16'h0, ppm_cap[15:0]};
            default: return {`CFM_RESP_SLVERR, 32'h0};
        endcase
    endfunction

    task automatic print_verdict();
        $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // one axi4-lite write or read, ready raised after a random stall
    task automatic bus(input bit we, input logic [9:0] i, input logic [31:0] v);
        logic [33:0] e;
        int n, slow;
        bit done;
        @(posedge mclk);
        e = exp_rd(i);
        slow = rnd() % 4;
        n = 0;
        done = 0;
        s_axi_awaddr <= {i, 2'b00};
        s_axi_araddr <= {i, 2'b00};
        s_axi_wdata <= v;
        s_axi_awvalid <= we;
        s_axi_wvalid <= we;
        s_axi_arvalid <= !we;
        while (!done)
        begin
            @(posedge mclk);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            done = (s_axi_bvalid && s_axi_bready)
                || (s_axi_rvalid && s_axi_rready);
            if (!done && n >= slow) s_axi_bready <= we;
            if (!done && n >= slow) s_axi_rready <= !we;
        end
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
        if (we) `CHK(s_axi_bresp, e[33:32])
        else `CHK({s_axi_rresp, s_axi_rdata}, e)
        if (we)
            case (i)
                `CFM_IDX_SOFT_MASK: soft_m = v[15:0];
                `CFM_IDX_EXT_MASK: ext_m = v[15:0];
                `CFM_IDX_STATUS: stat = stat & ~v[11:0];
                `CFM_IDX_REF_WINDOW: refw = v[13:0];
                `CFM_IDX_EXPECT: expc = v[15:0];
                default: ;
            endcase
    endtask

    task automatic do_reset();
        nrst <= 1'b0;
        repeat (3) @(posedge mclk);
        nrst <= 1'b1;
        soft_m = `CFM_MASK_RST;
        ext_m = `CFM_MASK_RST;
        stat = `CFM_STATUS_RST;
        refw = `CFM_REF_WINDOW_RST;
        expc = `CFM_EXPECT_RST;
        ppm_cap = `CFM_EXPECT_RST;
    endtask

    task automatic fire(input int b);
        @(posedge mclk);
        if (b == 2) conv[rnd() % 4] <= 1'b1;
        else det[b] <= 1'b1;
        repeat (2) @(posedge mclk);
        det <= '0;
        conv <= '0;
        stat = stat | (1 << b);
    endtask

    task automatic chk_out();
        repeat (4) @(posedge mclk);
        `CHK(soft_reset_request, |(stat[11:0] & soft_m[11:0]))
        `CHK(recovery_interrupt_pin_n, ~|(stat[11:0] & ext_m[11:0]))
    endtask

    initial
    begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // reference, monitored toggles, window spacing and run limit
    always @(posedge mclk)
    begin
        tick <= tick + 1;
        if (run && tick % 12 == 0) reference_toggle <= ~reference_toggle;
        if (run && tick % 3 == 0) monitored_toggle <= ~monitored_toggle;
        if (ppm_window_done)
        begin
            gap <= tick - last_done;
            last_done <= tick;
        end
        if (tick == 10000)
        begin
            mismatches++;
            print_verdict();
        end
    end

    initial
    begin
        {nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, det, conv} = '0;
        {s_axi_awprot, s_axi_arprot} = '0;
        s_axi_wstrb = 4'hf;
        do_reset();
        foreach (idx[k]) bus(0, idx[k], 0);
        for (int k = 6; k < 8; k++) bus(1, idx[k], rnd());
        for (int k = 0; k < 5; k++) if (k != 2) bus(1, idx[k], rnd());
        foreach (idx[k]) bus(0, idx[k], 0);
        for (int b = 0; b < 12; b++)
        begin
            d = rnd();
            bus(1, `CFM_IDX_SOFT_MASK, d);
            bus(1, `CFM_IDX_EXT_MASK, ~d);
            fire(b);
            chk_out();
            bus(1, `CFM_IDX_STATUS, ~(32'h1 << b));
            bus(0, `CFM_IDX_STATUS, 0);
            bus(1, `CFM_IDX_STATUS, 32'h1 << b);
            chk_out();
            bus(0, `CFM_IDX_STATUS, 0);
        end
        // a clear that meets a standing event leaves the bit set
        det[0] <= 1'b1;
        repeat (4) @(posedge mclk);
        bus(1, `CFM_IDX_STATUS, 32'h1);
        stat = 1;
        bus(0, `CFM_IDX_STATUS, 0);
        det <= '0;
        chk_out();
        bus(1, `CFM_IDX_STATUS, 32'h1);
        run <= 1'b1;
        for (int w = 0; w < 4; w += 3)
        begin
            bus(1, `CFM_IDX_REF_WINDOW, 32'(w));
            repeat (60 * (w + 1)) @(posedge mclk);
            `CHK(gap, 12 * (w + 1))
            ppm_cap = 4 * (w + 1);
            bus(0, `CFM_IDX_PPM_STATUS, 0);
        end
        run <= 1'b0;
        fire(5);
        chk_out();
        do_reset();
        foreach (idx[k]) bus(0, idx[k], 0);
        chk_out();
        print_verdict();
    end
endmodule // tb_cfm_monitor
